// *** src/agc_pkg.sv ***
package agc_pkg;

  // Register offsets
  localparam logic [7:0] AGC_ADDR_STATUS  = 8'h00;
  localparam logic [7:0] AGC_ADDR_GENERAL = 8'h01;
  localparam logic [7:0] AGC_ADDR_DATA    = 8'h02;
  localparam logic [7:0] AGC_ADDR_OSR     = 8'h03;

  // Status register fields
  localparam int AGC_ST_FIXED_ONE  = 7;
  localparam int AGC_ST_RMS_DONE   = 4;
  localparam int AGC_ST_AVG_DONE   = 3;
  localparam int AGC_ST_CRC_IN_ERR = 1;
  localparam int AGC_ST_BROWN_OUT  = 0;
  localparam logic [7:0] AGC_ST_W1C_MASK = 8'h1b;
  localparam logic [7:0] AGC_ST_RESET    = 8'h01;

  // General control fields
  localparam int AGC_GC_ROOT_MEAN_SQUARE_ENABLE   = 7;
  localparam int AGC_GC_CRC_EN   = 6;
  localparam int AGC_GC_STATISTICS_ENABLE = 5;
  localparam int AGC_GC_WIN_EN   = 4;
  localparam int AGC_GC_CONV_ST  = 3;
  localparam int AGC_GC_FORCE_AN = 2;
  localparam int AGC_GC_OFS_CAL  = 1;
  localparam int AGC_GC_SW_RST   = 0;
  localparam logic [7:0] AGC_GC_STORE_MASK = 8'hf6;
  localparam logic [7:0] AGC_GC_RESET      = 8'h00;

  // Output data format fields
  localparam int AGC_DF_FIXED_PAT = 7;
  localparam int AGC_DF_APPEND_LO = 4;
  localparam logic [7:0] AGC_DF_STORE_MASK = 8'hb0;
  localparam logic [7:0] AGC_DF_RESET      = 8'h00;

  // Averaging ratio fields
  localparam int AGC_OS_RATIO_LO = 0;
  localparam logic [7:0] AGC_OS_STORE_MASK = 8'h07;
  localparam logic [7:0] AGC_OS_RESET      = 8'h00;

  // Append codes
  localparam logic [1:0] AGC_APP_NONE   = 2'h0;
  localparam logic [1:0] AGC_APP_CHAN   = 2'h1;
  localparam logic [1:0] AGC_APP_STATUS = 2'h2;

  localparam logic [11:0] AGC_FIXED_CODE = 12'ha5a;

  typedef enum logic [2:0] {
    AGC_CONV_IDLE    = 3'h1,
    AGC_CONV_STRETCH = 3'h2,
    AGC_CONV_FREE    = 3'h4
  } agc_conv_e;

endpackage

// *** src/agc_config_regs.sv ***
module agc_config_regs
  import agc_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        crc_mismatch_i,
  input  wire logic        averaging_done_i,
  input  wire logic        rms_done_i,
  input  wire logic        calibration_done_i,
  input  wire logic        brown_out_i,
  input  wire logic        ninth_falling_edge_i,
  input  wire logic        conversion_done_i,
  input  wire logic [11:0] adc_code_i,
  input  wire logic [3:0]  channel_id_i,
  input  wire logic [3:0]  status_nibble_i,
  output logic [7:0]       reg_rdata_o,
  output logic             reg_rvalid_o,
  output logic             root_mean_square_enable_o,
  output logic             root_mean_square_clear_o,
  output logic             crc_enable_o,
  output logic             statistics_enable_o,
  output logic             statistics_clear_o,
  output logic             window_comparator_enable_o,
  output logic             window_comparator_reset_o,
  output logic             conversion_start_o,
  output logic             scl_stretch_o,
  output logic             force_all_analog_o,
  output logic             offset_calibration_run_o,
  output logic             write_blocked_o,
  output logic [1:0]       append_mode_o,
  output logic [7:0]       averaging_count_o,
  output logic [15:0]      data_word_o
);

  logic [7:0]  status_r;
  logic [7:0]  status_nxt;
  logic [7:0]  general_r;
  logic [7:0]  general_nxt;
  logic [7:0]  format_r;
  logic [7:0]  format_nxt;
  logic [7:0]  ratio_r;
  logic [7:0]  ratio_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  logic [15:0] data_r;
  logic [15:0] data_nxt;
  logic        rms_clr_r;
  logic        rms_clr_nxt;
  logic        stats_clr_r;
  logic        stats_clr_nxt;
  logic        start_r;
  logic        start_nxt;
  agc_conv_e   conv_r;
  agc_conv_e   conv_nxt;
  logic        bo_meta_r;
  logic        bo_sync_r;
  logic        bo_last_r;
  logic        write_ok;
  logic        sw_start;
  logic [1:0]  append_eff;
  logic [3:0]  append_bits;

  // Brown-out arrives from analog supervisor, not this clock
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      bo_meta_r <= 1'b0;
      bo_sync_r <= 1'b0;
      bo_last_r <= 1'b0;
    end else begin
      bo_meta_r <= brown_out_i;
      bo_sync_r <= bo_meta_r;
      bo_last_r <= bo_sync_r;
    end
  end

  // Only status and general control pass while CRC error is pending
  assign write_ok = reg_wr_i && (!status_r[AGC_ST_CRC_IN_ERR] ||
                    reg_addr_i == AGC_ADDR_STATUS ||
                    reg_addr_i == AGC_ADDR_GENERAL);
  assign sw_start = write_ok && reg_addr_i == AGC_ADDR_GENERAL &&
                    reg_wdata_i[AGC_GC_CONV_ST];

  // Reserved bits are masked on write and masked again on read
  // Register bank next state
  always_comb begin
    status_nxt    = status_r;
    general_nxt   = general_r;
    format_nxt    = format_r;
    ratio_nxt     = ratio_r;
    rms_clr_nxt   = 1'b0;
    stats_clr_nxt = 1'b0;
    if (calibration_done_i) begin
      general_nxt[AGC_GC_OFS_CAL] = 1'b0;
    end
    if (write_ok) begin
      case (reg_addr_i)
        AGC_ADDR_STATUS: begin
          status_nxt = status_r & ~(reg_wdata_i & AGC_ST_W1C_MASK);
        end
        AGC_ADDR_GENERAL: begin
          // Start and reset bits are never stored
          general_nxt   = reg_wdata_i & AGC_GC_STORE_MASK;
          rms_clr_nxt   = reg_wdata_i[AGC_GC_ROOT_MEAN_SQUARE_ENABLE];
          stats_clr_nxt = reg_wdata_i[AGC_GC_STATISTICS_ENABLE];
        end
        AGC_ADDR_DATA: begin
          format_nxt = reg_wdata_i & AGC_DF_STORE_MASK;
        end
        AGC_ADDR_OSR: begin
          ratio_nxt = reg_wdata_i & AGC_OS_STORE_MASK;
        end
        default: begin
        end
      endcase
    end
    // Events set after clears so a same-cycle set is kept
    if (averaging_done_i) begin
      status_nxt[AGC_ST_AVG_DONE] = 1'b1;
    end
    if (rms_done_i) begin
      status_nxt[AGC_ST_RMS_DONE] = 1'b1;
    end
    if (crc_mismatch_i && general_r[AGC_GC_CRC_EN]) begin
      status_nxt[AGC_ST_CRC_IN_ERR] = 1'b1;
    end
    if (bo_sync_r && !bo_last_r) begin
      status_nxt[AGC_ST_BROWN_OUT] = 1'b1;
    end
    if (write_ok && reg_addr_i == AGC_ADDR_GENERAL &&
        reg_wdata_i[AGC_GC_SW_RST]) begin
      // Completes in one cycle, so the bit never reads as 1
      status_nxt    = AGC_ST_RESET;
      general_nxt   = AGC_GC_RESET;
      format_nxt    = AGC_DF_RESET;
      ratio_nxt     = AGC_OS_RESET;
      rms_clr_nxt   = 1'b0;
      stats_clr_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      status_r    <= AGC_ST_RESET;
      general_r   <= AGC_GC_RESET;
      format_r    <= AGC_DF_RESET;
      ratio_r     <= AGC_OS_RESET;
      rms_clr_r   <= 1'b0;
      stats_clr_r <= 1'b0;
    end else begin
      status_r    <= status_nxt;
      general_r   <= general_nxt;
      format_r    <= format_nxt;
      ratio_r     <= ratio_nxt;
      rms_clr_r   <= rms_clr_nxt;
      stats_clr_r <= stats_clr_nxt;
    end
  end

  // Unmapped reads answer zero rather than stall the host
  // Read port, answered one cycle after the strobe
  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = reg_rd_i;
    if (reg_rd_i) begin
      case (reg_addr_i)
        AGC_ADDR_STATUS: begin
          rdata_nxt = (status_r & AGC_ST_W1C_MASK) |
                      (8'h01 << AGC_ST_FIXED_ONE);
        end
        AGC_ADDR_GENERAL: rdata_nxt = general_r & AGC_GC_STORE_MASK;
        AGC_ADDR_DATA:    rdata_nxt = format_r & AGC_DF_STORE_MASK;
        AGC_ADDR_OSR:     rdata_nxt = ratio_r & AGC_OS_STORE_MASK;
        default:          rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // Soft reset leaves a running conversion to finish
  // Starts seen outside idle are dropped, not queued
  // Conversion trigger; stretching stays until converter reports done
  always_comb begin
    conv_nxt  = conv_r;
    start_nxt = 1'b0;
    case (conv_r)
      AGC_CONV_IDLE: begin
        if (sw_start) begin
          conv_nxt  = AGC_CONV_FREE;
          start_nxt = 1'b1;
        end else if (ninth_falling_edge_i) begin
          conv_nxt  = AGC_CONV_STRETCH;
          start_nxt = 1'b1;
        end
      end
      AGC_CONV_STRETCH: begin
        if (conversion_done_i) begin
          conv_nxt = AGC_CONV_IDLE;
        end
      end
      AGC_CONV_FREE: begin
        if (conversion_done_i) begin
          conv_nxt = AGC_CONV_IDLE;
        end
      end
      default: conv_nxt = AGC_CONV_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      conv_r  <= AGC_CONV_IDLE;
      start_r <= 1'b0;
    end else begin
      conv_r  <= conv_nxt;
      start_r <= start_nxt;
    end
  end

  // Word is captured on done, so a late format change waits
  // Output word: 12-bit code then 4-bit append, zero if none
  assign append_eff = (format_r[AGC_DF_APPEND_LO +: 2] == AGC_APP_CHAN ||
                       format_r[AGC_DF_APPEND_LO +: 2] == AGC_APP_STATUS)
                      ? format_r[AGC_DF_APPEND_LO +: 2]
                      : AGC_APP_NONE;

  always_comb begin
    case (append_eff)
      AGC_APP_CHAN:   append_bits = channel_id_i;
      AGC_APP_STATUS: append_bits = status_nibble_i;
      default:        append_bits = 4'h0;
    endcase
    data_nxt = data_r;
    if (conversion_done_i) begin
      data_nxt = {format_r[AGC_DF_FIXED_PAT] ? AGC_FIXED_CODE : adc_code_i,
                  append_bits};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      data_r <= 16'h0000;
    end else begin
      data_r <= data_nxt;
    end
  end

  assign reg_rdata_o                = rdata_r;
  assign reg_rvalid_o               = rvalid_r;
  assign root_mean_square_enable_o  = general_r[AGC_GC_ROOT_MEAN_SQUARE_ENABLE];
  assign root_mean_square_clear_o   = rms_clr_r;
  assign crc_enable_o               = general_r[AGC_GC_CRC_EN];
  assign statistics_enable_o        = general_r[AGC_GC_STATISTICS_ENABLE];
  assign statistics_clear_o         = stats_clr_r;
  assign window_comparator_enable_o = general_r[AGC_GC_WIN_EN];
  assign window_comparator_reset_o  = !general_r[AGC_GC_WIN_EN];
  assign conversion_start_o         = start_r;
  assign scl_stretch_o              = (conv_r == AGC_CONV_STRETCH);
  assign force_all_analog_o         = general_r[AGC_GC_FORCE_AN];
  assign offset_calibration_run_o   = general_r[AGC_GC_OFS_CAL];
  assign write_blocked_o            = status_r[AGC_ST_CRC_IN_ERR];
  assign append_mode_o              = append_eff;
  // Count runs one to 128; the averaging engine reads it directly
  assign averaging_count_o          =
    8'h01 << ratio_r[AGC_OS_RATIO_LO +: 3];
  assign data_word_o                = data_r;

endmodule

// *** tb/agc_conv_model.sv ***
module agc_conv_model (
  input  wire logic       clk_sys_i,
  input  wire logic       start_i,
  input  wire logic       cal_i,
  input  wire logic [3:0] lat_i,
  output logic            done_o,
  output logic            cal_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_r = 5'h0;
  logic [4:0] ccnt_r = 5'h0;
  initial done_o = 1'b0;
  initial cal_done_o = 1'b0;
  // Latency from the bench, so answers come both promptly and slowly
  always @(posedge clk_sys_i) begin
    done_o <= (cnt_r == 5'h1);
    cal_done_o <= (ccnt_r == 5'h1);
    if (start_i)
      cnt_r <= {1'b0, lat_i} + 5'h1;
    else if (cnt_r != 5'h0)
      cnt_r <= cnt_r - 5'h1;
    // Guard on done stops a second run while the trim bit falls
    if (cal_i && ccnt_r == 5'h0 && !cal_done_o)
      ccnt_r <= {1'b0, lat_i} + 5'h2;
    else if (ccnt_r != 5'h0)
      ccnt_r <= ccnt_r - 5'h1;
  end
endmodule

// *** tb/agc_config_regs_sva.sv ***
module agc_config_regs_sva (
  input wire logic       clk_sys_i,
  input wire logic       reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic       calibration_done_i,
  input wire logic       conversion_done_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       reg_rvalid_o,
  input wire logic       root_mean_square_clear_o,
  input wire logic       statistics_clear_o,
  input wire logic       conversion_start_o,
  input wire logic       scl_stretch_o,
  input wire logic       offset_calibration_run_o,
  input wire logic [1:0] append_mode_o,
  input wire logic [7:0] averaging_count_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Soft reset bit discards the rest of the write except the start bit
  sequence gen_wr(int b);
    reg_wr_i && reg_addr_i == 8'h01 && reg_wdata_i[b] && !reg_wdata_i[0];
  endsequence
  rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read without answer");
  start_zero_a: assert property (reg_rd_i && reg_addr_i == 8'h01
    |=> !reg_rdata_o[3]) else $error("start bit read as one");
  rms_clear_a: assert property (gen_wr(7) |=> root_mean_square_clear_o)
    else $error("rms clear missing");
  stats_clear_a: assert property (gen_wr(5) |=> statistics_clear_o)
    else $error("stats clear missing");
  stretch_hold_a: assert property (scl_stretch_o && !conversion_done_i
    |=> scl_stretch_o) else $error("stretch dropped early");
  stretch_end_a: assert property (conversion_done_i |=> !scl_stretch_o)
    else $error("stretch held after done");
  stretch_start_a: assert property ($rose(scl_stretch_o)
    |-> conversion_start_o) else $error("stretch without start");
  sw_start_a: assert property (gen_wr(3) ##1 conversion_start_o
    |-> !scl_stretch_o) else $error("stretch on soft start");
  cal_clear_a: assert property (calibration_done_i
    && !(reg_wr_i && reg_addr_i == 8'h01 && reg_wdata_i[1])
    |=> !offset_calibration_run_o) else $error("trim bit stuck");
  sw_reset_a: assert property (reg_wr_i && reg_addr_i == 8'h01
    && reg_wdata_i[0] |=> averaging_count_o == 8'h01 && append_mode_o == 2'h0)
    else $error("soft reset left values");
  append_a: assert property (append_mode_o != 2'h3)
    else $error("reserved append code");
endmodule

bind agc_config_regs agc_config_regs_sva u_sva (.clk_sys_i, .reset_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .calibration_done_i,
  .conversion_done_i, .reg_rdata_o, .reg_rvalid_o, .root_mean_square_clear_o,
  .statistics_clear_o, .conversion_start_o, .scl_stretch_o,
  .offset_calibration_run_o, .append_mode_o, .averaging_count_o);

// *** tb/adc_general_data_osr_config_test.sv ***
module adc_general_data_osr_config_test
  import agc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 0, reset_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  logic crc_mismatch_i = 0, averaging_done_i = 0, rms_done_i = 0;
  logic brown_out_i = 0, ninth_falling_edge_i = 0;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, rnd = 8'd27, d;
  logic [11:0] adc_code_i = 0;
  logic [3:0] channel_id_i = 0, status_nibble_i = 0, lat = 4'h3;
  logic [7:0] dfs [4] = '{8'h00, 8'h10, 8'h20, 8'h80};
  wire [7:0] reg_rdata_o, averaging_count_o;
  wire [15:0] data_word_o;
  wire [1:0] append_mode_o;
  wire reg_rvalid_o, root_mean_square_enable_o, root_mean_square_clear_o;
  wire crc_enable_o, statistics_enable_o, statistics_clear_o;
  wire window_comparator_enable_o, window_comparator_reset_o;
  wire conversion_start_o, scl_stretch_o, force_all_analog_o;
  wire offset_calibration_run_o, write_blocked_o;
  wire conversion_done_i, calibration_done_i;
  wire [5:0] en_vec = {root_mean_square_enable_o, crc_enable_o,
    statistics_enable_o, window_comparator_enable_o,
    window_comparator_reset_o, force_all_analog_o};
  int n_errors = 0, total_checks = 0, cyc = 0;

  agc_config_regs u_agc_config_regs (.clk_sys_i, .reset_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .crc_mismatch_i, .averaging_done_i,
    .rms_done_i, .calibration_done_i, .brown_out_i, .ninth_falling_edge_i,
    .conversion_done_i, .adc_code_i, .channel_id_i, .status_nibble_i,
    .reg_rdata_o, .reg_rvalid_o, .root_mean_square_enable_o,
    .root_mean_square_clear_o, .crc_enable_o, .statistics_enable_o,
    .statistics_clear_o, .window_comparator_enable_o,
    .window_comparator_reset_o, .conversion_start_o, .scl_stretch_o,
    .force_all_analog_o, .offset_calibration_run_o, .write_blocked_o,
    .append_mode_o, .averaging_count_o, .data_word_o);
  agc_conv_model u_agc_conv_model (.clk_sys_i, .start_i(conversion_start_o),
    .cal_i(offset_calibration_run_o), .lat_i(lat),
    .done_o(conversion_done_i), .cal_done_o(calibration_done_i));

  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      test_done();
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [15:0] exp_word(input logic [7:0] df);
    exp_word[15:4] = df[7] ? 12'ha5a : adc_code_i;
    exp_word[3:0] = df[5:4] == 2'h1 ? channel_id_i
                  : df[5:4] == 2'h2 ? status_nibble_i : 4'h0;
  endfunction
  task automatic chk(input string n, input logic [15:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    @(posedge clk_sys_i);
    #1 s = 0;
  endtask
  task automatic wr(input logic [7:0] a, v);
    reg_addr_i = a;
    reg_wdata_i = v;
    pulse(reg_wr_i);
    @(posedge clk_sys_i) #1;
  endtask
  task automatic rd(input logic [7:0] a, e);
    reg_addr_i = a;
    pulse(reg_rd_i);
    chk($sformatf("reg %h", a), {8'h01, e}, {7'h0, reg_rvalid_o, reg_rdata_o});
    @(posedge clk_sys_i) #1;
  endtask
  task automatic conv(input logic sw, input logic [7:0] df);
    int i;
    {adc_code_i, channel_id_i, status_nibble_i} = {rnd, rnd, rnd[3:0]};
    lat = rnd[3:0];
    if (sw)
      wr(8'h01, 8'h08);
    else
      pulse(ninth_falling_edge_i);
    chk("stretch", {15'h0, !sw}, {15'h0, scl_stretch_o});
    for (i = 0; i < 40 && !conversion_done_i; i++)
      @(posedge clk_sys_i) #1;
    @(posedge clk_sys_i) #1;
    chk("word", exp_word(df), data_word_o);
    rnd = lfsr(rnd);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_sys_i);
    #1 reset_i = 0;
    foreach (dfs[k]) rd(8'(k), k == 0 ? 8'h81 : 8'h00);
    rd(8'h10, 8'h00);
    $display("reset values done");
    for (int k = 0; k < 12; k++) begin
      d = k < 8 ? {rnd[7:6], k[1:0], rnd[3], k[2:0]} : rnd;
      wr(8'h03, d);
      rd(8'h03, d & 8'h07);
      chk("count", 16'(9'h1 << d[2:0]), 16'(averaging_count_o));
      wr(8'h02, d);
      rd(8'h02, d & 8'hb0);
      chk("append", d[5:4] == 2'h3 ? 16'h0 : 16'(d[5:4]), 16'(append_mode_o));
      rnd = lfsr(rnd);
    end
    $display("formats done");
    foreach (dfs[k]) begin
      wr(8'h02, dfs[k]);
      conv(k[0], dfs[k]);
    end
    $display("conversions done");
    wr(8'h01, 8'hac);
    rd(8'h01, 8'ha4);
    chk("force", 16'h1, 16'(force_all_analog_o));
    chk("enables", 16'h2b, 16'(en_vec));
    wr(8'h01, 8'h02);
    for (int i = 0; i < 40 && offset_calibration_run_o; i++)
      @(posedge clk_sys_i) #1;
    rd(8'h01, 8'h00);
    $display("general done");
    wr(8'h00, 8'h01);
    rd(8'h00, 8'h80);
    pulse(averaging_done_i);
    pulse(rms_done_i);
    rd(8'h00, 8'h98);
    wr(8'h00, 8'h18);
    rd(8'h00, 8'h80);
    wr(8'h03, 8'h05);
    wr(8'h01, 8'h40);
    chk("crc en", 16'h1, 16'(crc_enable_o));
    pulse(crc_mismatch_i);
    chk("blocked", 16'h1, 16'(write_blocked_o));
    wr(8'h03, 8'h02);
    rd(8'h03, 8'h05);
    wr(8'h01, 8'h44);
    rd(8'h01, 8'h44);
    wr(8'h00, 8'h02);
    chk("unblocked", 16'h0, 16'(write_blocked_o));
    wr(8'h03, 8'h02);
    rd(8'h03, 8'h02);
    $display("status done");
    wr(8'h01, 8'h01);
    rd(8'h00, 8'h81);
    rd(8'h03, 8'h00);
    $display("soft reset done");
    test_done();
  end
endmodule
